// ===== shared/pcg_pkg.sv
// Package with register map, field layout and reset values of the clock gating block.
package pcg_pkg;
   // Register byte offsets on the APB.
   localparam logic [11:0] PCG_OFF_RUN0    = 12'h0100;
   localparam logic [11:0] PCG_OFF_RUN1    = 12'h0104;
   localparam logic [11:0] PCG_OFF_SLP0    = 12'h0110;
   localparam logic [11:0] PCG_OFF_SLP1    = 12'h0114;
   localparam logic [11:0] PCG_OFF_DSLP0   = 12'h0120;
   localparam logic [11:0] PCG_OFF_DSLP1   = 12'h0124;
   localparam logic [11:0] PCG_OFF_CFG     = 12'h0060;
   localparam logic [11:0] PCG_OFF_IRQ_ST  = 12'h0050;
   localparam logic [11:0] PCG_OFF_IRQ_EN  = 12'h0054;
   localparam logic [11:0] PCG_OFF_IRQ_CLR = 12'h0058;
   // Set-0 field positions.
   localparam int PCG_B_PWM  = 20;
   localparam int PCG_B_ADC  = 16;
   localparam int PCG_B_RATE = 8;
   localparam int PCG_B_RSV1 = 6;
   localparam int PCG_B_WDT  = 3;
   // Writable masks and reset values.
   localparam logic [31:0] PCG_MASK0_RATE = 32'h0011_0308;
   localparam logic [31:0] PCG_MASK0      = 32'h0011_0008;
   localparam logic [31:0] PCG_MASK1      = 32'h010F_5011;
   localparam logic [31:0] PCG_RST0       = 32'h0000_0040;
   localparam logic [31:0] PCG_RST1       = 32'h0000_0000;
   localparam logic [31:0] PCG_ZERO       = 32'h0000_0000;
   // Unit index order of the gate vector.
   localparam int PCG_NUNITS = 11;
   // Interrupt event bits: fault on gated access, mode change.
   localparam int PCG_EV_FAULT = 0;
   localparam int PCG_EV_MODE  = 1;
   localparam int PCG_NEV      = 2;
   // Low power state of the processor.
   typedef enum logic [1:0] {PCG_RUN, PCG_SLEEP, PCG_DEEP} pcg_mode_type;
endpackage

// ===== shared/pcg_gate_if.sv
// Interface carrying enables and fault check between the register file and the gate bank.
`timescale 1ns/1ns
`default_nettype none
interface pcg_gate_if #(parameter int N = 11);
   logic [N-1:0] enable;
   logic [N-1:0] access;
   logic         fault;
   modport ctrl (output enable, output access, input fault);
   modport gate (input enable, input access, output fault);
endinterface
`default_nettype wire

// ===== rtl/pcg_gate_bank.sv
// Registered per-unit clock enables and bus fault detection for gated units.
`timescale 1ns/1ns
`default_nettype none
module pcg_gate_bank
   import pcg_pkg::*;
#(
   parameter int N = PCG_NUNITS
)(
   input  wire logic clk,
   input  wire logic srst,
   pcg_gate_if.gate  gif,
   output logic [N-1:0] gate_en_reg
);
   // Gate enables follow the effective enable one edge later, off in reset.
   always_ff @(posedge clk)
   begin
      if (srst)
         gate_en_reg <= '0;
      else
         gate_en_reg <= gif.enable;
   end

   // An access to a unit whose clock is gated off is a fault.
   always_comb
   begin
      gif.fault = |(gif.access & ~gate_en_reg);
   end
endmodule
`default_nettype wire

// ===== rtl/pcg_top.sv
// Peripheral clock gating control with APB registers, mode select and gated-access faults.
// Operation
// - Set gate bit clocks its unit; cleared bit stops and disables it.
// - Access to a unit with its clock gated off answers with bus fault.
// - All gate bits clear at reset unless another reset value is defined.
// - Run, sleep and deep-sleep copies of each gate register, independent.
// - Sleep copies act only while auto gating select bit is set.
// - Set-0 bit 20 gates the PWM unit, resets to zero.
// - Set-0 bit 16 gates converter 0, resets to zero.
// - Set-0 bit 3 gates the watchdog, resets to zero.
// - Sleep set-0 bits 9:8 hold sample rate; deep-sleep has none.
// - Sleep and deep-sleep set-0 bit 6 reads one; reset 0x40.
// - Run set-1 gates comparator, four timers, two-wire, serial ports.
// - Run set-0 at 0x100 mirrors sleep layout, resets to 0x40.
`timescale 1ns/1ns
`default_nettype none
module pcg_top
   import pcg_pkg::*;
#(
   parameter int NUNITS = PCG_NUNITS
)(
   input  wire logic              CLK_SYS,
   input  wire logic              SRST,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [11:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic                   PREADY,
   output logic [31:0]            PRDATA,
   output logic                   PSLVERR,
   input  wire logic              SLEEP_REQ,
   input  wire logic              DEEP_REQ,
   input  wire logic [NUNITS-1:0] UNIT_ACCESS,
   output logic                   UNIT_FAULT,
   output logic [NUNITS-1:0]      UNIT_CLK_EN,
   output logic [1:0]             SAMPLE_RATE,
   output logic                   IRQ
);
   logic [31:0]        run0_reg;
   logic [31:0]        run1_reg;
   logic [31:0]        slp0_reg;
   logic [31:0]        slp1_reg;
   logic [31:0]        dslp0_reg;
   logic [31:0]        dslp1_reg;
   logic               auto_gating_select_reg;
   logic [PCG_NEV-1:0] irq_st_reg;
   logic [PCG_NEV-1:0] irq_en_reg;
   pcg_mode_type       mode_reg;
   pcg_mode_type       mode_next;
   logic [31:0]        sel0;
   logic [31:0]        sel1;
   logic [31:0]        rdata_next;
   logic               wr_acc;
   logic               rd_acc;
   logic               addr_ok;
   logic [PCG_NEV-1:0] ev;
   pcg_gate_if #(.N(NUNITS)) gif ();

   // Unit order: 0 PWM, 1 converter, 2 watchdog, 3 comparator, 4-7 timers,
   // 8-9 two-wire, 10 sync serial. Async serial is folded via function below.
   function automatic logic [NUNITS-1:0] units(input logic [31:0] s0, input logic [31:0] s1);
      logic [NUNITS-1:0] u;
      u = '0;
      u[0]  = s0[PCG_B_PWM];
      u[1]  = s0[PCG_B_ADC];
      u[2]  = s0[PCG_B_WDT];
      u[3]  = s1[24];
      u[4]  = s1[16];
      u[5]  = s1[17];
      u[6]  = s1[18];
      u[7]  = s1[19];
      u[8]  = s1[12];
      u[9]  = s1[14];
      u[10] = s1[4] | s1[0];
      return u;
   endfunction

   // Masked write of a register keeping read-only bits fixed.
   function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] d,
                                         input logic [31:0] m, input logic [31:0] fixed);
      return ((old & ~m) | (d & m)) | fixed;
   endfunction

   // APB decode; every transfer completes in its second access cycle, after one wait state.
   assign wr_acc = PSEL & PENABLE & PWRITE;
   assign rd_acc = PSEL & PENABLE & ~PWRITE;

   // Address decode and read mux.
   always_comb
   begin
      addr_ok    = 1'b1;
      rdata_next = PCG_ZERO;
      case (PADDR)
         PCG_OFF_RUN0:    rdata_next = run0_reg;
         PCG_OFF_RUN1:    rdata_next = run1_reg;
         PCG_OFF_SLP0:    rdata_next = slp0_reg;
         PCG_OFF_SLP1:    rdata_next = slp1_reg;
         PCG_OFF_DSLP0:   rdata_next = dslp0_reg;
         PCG_OFF_DSLP1:   rdata_next = dslp1_reg;
         PCG_OFF_CFG:     rdata_next = {31'h0000_0000, auto_gating_select_reg};
         PCG_OFF_IRQ_ST:  rdata_next = {30'h0000_0000, irq_st_reg};
         PCG_OFF_IRQ_EN:  rdata_next = {30'h0000_0000, irq_en_reg};
         PCG_OFF_IRQ_CLR: rdata_next = PCG_ZERO;
         default:         addr_ok = 1'b0;
      endcase
   end

   // Bus answer registers: ready pulses in the access cycle's edge... one-cycle wait.
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         PREADY  <= 1'b0;
         PRDATA  <= PCG_ZERO;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PREADY  <= PSEL & PENABLE & ~PREADY;
         PSLVERR <= PSEL & PENABLE & ~PREADY & ~addr_ok;
         PRDATA  <= (rd_acc & ~PREADY & addr_ok) ? rdata_next : PCG_ZERO;
      end
   end

   // Gate register copies; writes land on the edge where PREADY is sampled high.
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         run0_reg  <= PCG_RST0;
         slp0_reg  <= PCG_RST0;
         dslp0_reg <= PCG_RST0;
         run1_reg  <= PCG_RST1;
         slp1_reg  <= PCG_RST1;
         dslp1_reg <= PCG_RST1;
      end
      else if (wr_acc & PREADY)
      begin
         case (PADDR)
            PCG_OFF_RUN0:  run0_reg  <= wmask(run0_reg, PWDATA, PCG_MASK0_RATE, PCG_RST0);
            PCG_OFF_SLP0:  slp0_reg  <= wmask(slp0_reg, PWDATA, PCG_MASK0_RATE, PCG_RST0);
            PCG_OFF_DSLP0: dslp0_reg <= wmask(dslp0_reg, PWDATA, PCG_MASK0, PCG_RST0);
            PCG_OFF_RUN1:  run1_reg  <= wmask(run1_reg, PWDATA, PCG_MASK1, PCG_ZERO);
            PCG_OFF_SLP1:  slp1_reg  <= wmask(slp1_reg, PWDATA, PCG_MASK1, PCG_ZERO);
            PCG_OFF_DSLP1: dslp1_reg <= wmask(dslp1_reg, PWDATA, PCG_MASK1, PCG_ZERO);
            default:       run0_reg  <= run0_reg;
         endcase
      end
   end

   // Configuration and interrupt enable registers.
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         auto_gating_select_reg <= 1'b0;
         irq_en_reg             <= '0;
      end
      else if (wr_acc & PREADY)
      begin
         if (PADDR == PCG_OFF_CFG)
            auto_gating_select_reg <= PWDATA[0];
         if (PADDR == PCG_OFF_IRQ_EN)
            irq_en_reg <= PWDATA[PCG_NEV-1:0];
      end
   end

   // Power state follows the request inputs, deep sleep taking priority.
   always_comb
   begin
      if (DEEP_REQ)
         mode_next = PCG_DEEP;
      else if (SLEEP_REQ)
         mode_next = PCG_SLEEP;
      else
         mode_next = PCG_RUN;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
         mode_reg <= PCG_RUN;
      else
         mode_reg <= mode_next;
   end

   // Copy select: low power copies used only with auto gating on.
   always_comb
   begin
      sel0 = run0_reg;
      sel1 = run1_reg;
      if (auto_gating_select_reg)
      begin
         case (mode_reg)
            PCG_SLEEP:
            begin
               sel0 = slp0_reg;
               sel1 = slp1_reg;
            end
            PCG_DEEP:
            begin
               sel0 = dslp0_reg;
               sel1 = dslp1_reg;
            end
            default:
            begin
               sel0 = run0_reg;
               sel1 = run1_reg;
            end
         endcase
      end
   end

   assign gif.enable = units(sel0, sel1);
   assign gif.access = UNIT_ACCESS;

   pcg_gate_bank #(.N(NUNITS)) u_bank (
      .clk         (CLK_SYS),
      .srst        (SRST),
      .gif         (gif.gate),
      .gate_en_reg (UNIT_CLK_EN)
   );

   // Fault answer to the peripheral fabric, registered.
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         UNIT_FAULT  <= 1'b0;
         SAMPLE_RATE <= 2'h0;
      end
      else
      begin
         UNIT_FAULT  <= gif.fault;
         SAMPLE_RATE <= sel0[PCG_B_RATE +: 2];
      end
   end

   // Events: fault on gated access and change of power state.
   assign ev[PCG_EV_FAULT] = gif.fault;
   assign ev[PCG_EV_MODE]  = (mode_next != mode_reg);

   // Sticky status; a new event wins over a clear in the same cycle.
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
         irq_st_reg <= '0;
      else if (wr_acc & PREADY & (PADDR == PCG_OFF_IRQ_CLR))
         irq_st_reg <= (irq_st_reg & ~PWDATA[PCG_NEV-1:0]) | ev;
      else
         irq_st_reg <= irq_st_reg | ev;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
         IRQ <= 1'b0;
      else
         IRQ <= |(irq_st_reg & irq_en_reg);
   end
endmodule
`default_nettype wire

// ===== tb/pcg_top_checker.sv
// Checker for bus answers, reset state and gated-access faults of the clock gating block.
`timescale 1ns/1ns
`default_nettype none
module pcg_top_checker
   import pcg_pkg::*;
#(
   parameter int NUNITS = PCG_NUNITS
)(
   input wire logic              CLK_SYS,
   input wire logic              SRST,
   input wire logic              PSEL,
   input wire logic              PENABLE,
   input wire logic [11:0]       PADDR,
   input wire logic              PREADY,
   input wire logic [31:0]       PRDATA,
   input wire logic              PSLVERR,
   input wire logic [NUNITS-1:0] UNIT_ACCESS,
   input wire logic              UNIT_FAULT,
   input wire logic [NUNITS-1:0] UNIT_CLK_EN,
   input wire logic              IRQ
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SRST);
   // The answer follows one wait state, stands one cycle and has a cause.
   a_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("late ready");
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
   a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE)) else $error("stray ready");
   a_data_idle: assert property (!PREADY |-> PRDATA == PCG_ZERO && !PSLVERR) else $error("idle data");
   a_err_unmapped: assert property (PSEL && PENABLE && !PREADY && PADDR == 12'h0200 |=> PSLVERR)
      else $error("no slave error");
   // Reset leaves every unit unclocked and all flags low.
   a_reset_quiet: assert property (disable iff (1'b0) SRST |=> UNIT_CLK_EN == '0 && !UNIT_FAULT && !IRQ)
      else $error("reset state");
   // A gated unit faults on access; a clocked one never does.
   a_fault_gated: assert property ((UNIT_ACCESS & ~UNIT_CLK_EN) != '0 |=> $stable(UNIT_CLK_EN) -> UNIT_FAULT)
      else $error("missing fault");
   a_fault_clean: assert property ((UNIT_ACCESS & ~UNIT_CLK_EN) == '0 |=> $stable(UNIT_CLK_EN) -> !UNIT_FAULT)
      else $error("stray fault");
   // Main scenarios reached.
   c_fault: cover property (UNIT_FAULT);
   c_error: cover property (PREADY && PSLVERR);
   c_irq: cover property ($rose(IRQ));
endmodule
`default_nettype wire

// ===== tb/pcg_unit_model.sv
// Model of the gated peripheral units, which touch their bus and see the fault answer.
`timescale 1ns/1ns
`default_nettype none
module pcg_unit_model
   import pcg_pkg::*;
(
   input wire logic              clk,
   input wire logic              fault,
   output logic [PCG_NUNITS-1:0] access
);
   // No unit is touched until the bench asks.
   initial access = '0;
   // One access to unit u; the answer is taken while the access still stands.
   task automatic touch(input int u, output logic f);
      @(posedge clk);
      access <= PCG_NUNITS'(1) << u;
      @(posedge clk);
      #1 f = fault;
      @(posedge clk);
      access <= '0;
   endtask
endmodule
`default_nettype wire

// ===== tb/pcg_top_test.sv
// Self-checking bench for the clock gating block driven over its APB registers.
`timescale 1ns/1ns
`default_nettype none
module pcg_top_test;
   import pcg_pkg::*;
   logic        clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, slp = 0, dps = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, rd, prdata;
   logic [10:0] acc, en;
   logic [1:0]  rate;
   logic        prdy, perr, flt, irq, e, f;
   int          bad_count = 0, total_checks = 0;
   int          bits[3] = '{20, 16, 3};
   // System clock of 4 ns.
   always #2 clk = ~clk;
   pcg_top pcg_top_inst (.CLK_SYS(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PREADY(prdy), .PRDATA(prdata), .PSLVERR(perr), .SLEEP_REQ(slp), .DEEP_REQ(dps),
      .UNIT_ACCESS(acc), .UNIT_FAULT(flt), .UNIT_CLK_EN(en), .SAMPLE_RATE(rate), .IRQ(irq));
   pcg_unit_model pcg_unit_model_inst (.clk(clk), .fault(flt), .access(acc));
   // Counts a comparison and reports a mismatch at once.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until PREADY stands high; the answer is taken in that cycle.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
         #1;
      end
      while (prdy !== 1'b1);
      rd = prdata;
      e = perr;
      @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, PCG_ZERO);
      check(rd, exp);
   endtask
   // Lets registered enables and the interrupt follow a change.
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Main sequence.
   initial
   begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rdc(PCG_OFF_RUN0, 32'h0000_0040);
      rdc(PCG_OFF_RUN1, PCG_ZERO);
      rdc(PCG_OFF_SLP0, 32'h0000_0040);
      rdc(PCG_OFF_DSLP0, 32'h0000_0040);
      check(32'(en), PCG_ZERO);
      $display("reset test done");
      xfer(1'b1, PCG_OFF_RUN0, 32'hFFFF_FEFF);
      rdc(PCG_OFF_RUN0, 32'h0011_0248);
      xfer(1'b1, PCG_OFF_RUN1, 32'hFFFF_FFFF);
      rdc(PCG_OFF_RUN1, 32'h010F_5011);
      xfer(1'b1, PCG_OFF_SLP0, 32'h0010_0140);
      rdc(PCG_OFF_SLP0, 32'h0010_0140);
      xfer(1'b1, PCG_OFF_DSLP0, 32'hFFFF_FFFF);
      rdc(PCG_OFF_DSLP0, 32'h0011_0048);
      check(32'(en), 32'h0000_07FF);
      check(32'(rate), 32'h0000_0002);
      $display("register test done");
      // Each set-0 gate alone: its unit answers, the next one faults.
      for (int i = 0; i < 3; i++)
      begin
         xfer(1'b1, PCG_OFF_RUN0, 32'h0000_0001 << bits[i]);
         settle;
         check(32'(en[2:0]), 32'(1 << i));
         pcg_unit_model_inst.touch(i, f);
         check(32'(f), PCG_ZERO);
         pcg_unit_model_inst.touch((i + 1) % 3, f);
         check(32'(f), 32'h0000_0001);
      end
      rdc(PCG_OFF_IRQ_ST, 32'h0000_0001);
      check(32'(irq), PCG_ZERO);
      xfer(1'b1, PCG_OFF_IRQ_EN, 32'h0000_0001);
      settle;
      check(32'(irq), 32'h0000_0001);
      xfer(1'b1, PCG_OFF_IRQ_CLR, 32'h0000_0001);
      settle;
      check(32'(irq), PCG_ZERO);
      rdc(PCG_OFF_IRQ_ST, PCG_ZERO);
      $display("fault test done");
      // Sleep request counts only once auto gating is selected.
      slp <= 1'b1;
      settle;
      check(32'(en), 32'h0000_07FC);
      xfer(1'b1, PCG_OFF_CFG, 32'h0000_0001);
      settle;
      check(32'(en), 32'h0000_0001);
      check(32'(rate), 32'h0000_0001);
      dps <= 1'b1;
      settle;
      check(32'(en), 32'h0000_0007);
      check(32'(rate), PCG_ZERO);
      check(32'(irq), PCG_ZERO);
      $display("mode test done");
      xfer(1'b1, 12'h0200, 32'hFFFF_FFFF);
      check(32'(e), 32'h0000_0001);
      rdc(12'h0200, PCG_ZERO);
      check(32'(e), 32'h0000_0001);
      $display("unmapped test done");
      summarize();
   end
   // Watchdog against a hang.
   initial
   begin
      repeat (3000) @(posedge clk);
      bad_count++;
      summarize();
   end
endmodule
bind pcg_top pcg_top_checker #(.NUNITS(NUNITS)) pcg_top_checker_inst (.CLK_SYS(CLK_SYS), .SRST(SRST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
   .UNIT_ACCESS(UNIT_ACCESS), .UNIT_FAULT(UNIT_FAULT), .UNIT_CLK_EN(UNIT_CLK_EN), .IRQ(IRQ));
`default_nettype wire
